// *** logic/rectifier_defines.svh ***
// constants of the rectifier identity, control and status logic
// assumes a 50 MHz ref_clk and pin levels already digitised in millivolts
`ifndef RECTIFIER_DEFINES_SVH
`define RECTIFIER_DEFINES_SVH

// ==========================================================
// clock and timing
`define CLK_HZ 50000000
`define PG_PULSE_TIME_US 1000
`define OTW_LEAD_TIME_S 10
`define RAMP_TIME_MS 60
`define RAMP_SPAN_MV 10000

// ==========================================================
// position level thresholds, mv, falling from position 1 except the shelf windows, which rise
`define POS10_THR_MV '{16'd2835, 16'd2505, 16'd2175, 16'd1845, 16'd1515, \
                      16'd1185, 16'd855, 16'd525, 16'd180}
`define POS10_INVALID_MV 16'd3150
`define RACK_THR_MV '{16'd3050, 16'd2550, 16'd2050, 16'd1600, 16'd1200, 16'd750, 16'd250}
`define SHELF_MIN_MV '{16'd2300, 16'd4700, 16'd7400, 16'd9500, 16'd11800, \
                      16'd14200, 16'd16600, 16'd19000, 16'd21300, 16'd23800}
`define SHELF_MAX_MV '{16'd2700, 16'd5300, 16'd7600, 16'd10500, 16'd13200, \
                      16'd15800, 16'd18400, 16'd21000, 16'd23600, 16'd26300}

// ==========================================================
// voltage setpoint
`define HW_VOLTAGE_SETPOINT_PIN_DEFAULT_ABOVE_MV 16'd3000
`define HW_VOLTAGE_SETPOINT_PIN_GROUND_BELOW_MV 16'd100
`define VOUT_MIN_MV 16'd18000
`define VOUT_SPAN_MV 16'd40000
`define VOUT_DEFAULT_MV 16'd52000

// ==========================================================
// bus address layout and reset values
`define ADDR_BASE_BITS 3'h4
`define ADDR_FIELD_LSB 1
`define POS_NONE 4'h0
`define SLOT_SHORTED 4'ha
`endif

// *** logic/rectifier_pkg.sv ***
// types shared by the rectifier identity, control and status logic
// assumes the constants header is included by each design file
package rectifier_pkg;
  typedef enum logic [1:0] {
    OT_NORMAL = 2'b00,
    OT_WARNING = 2'b01,
    OT_SHUTDOWN = 2'b10
  } ot_state_e;
  typedef logic [3:0] pos_t;
  typedef logic [15:0] mv_t;
endpackage

// *** logic/position_quantiser.sv ***
// quantises unit, rack, slot and shelf pin levels into positions
// assumes levels arrive in millivolts, synchronous to the clock; 0 means none
`timescale 1ns/1ps
`include "rectifier_defines.svh"
module position_quantiser import rectifier_pkg::*; (
  input wire mv_t unit_level_mv,
  input wire mv_t rack_level_mv,
  input wire mv_t slot_level_mv,
  input wire mv_t shelf_level_mv,
  output pos_t unit_position_code,
  output pos_t rack_position_code,
  output pos_t slot_position,
  output pos_t shelf_position
);
  localparam mv_t POS10_THR [9] = `POS10_THR_MV;
  localparam mv_t RACK_THR [7] = `RACK_THR_MV;
  localparam mv_t SHELF_MIN [10] = `SHELF_MIN_MV;
  localparam mv_t SHELF_MAX [10] = `SHELF_MAX_MV;

  // ==========================================================
  // threshold votes, one per step
  logic [8:0] unit_hi;
  logic [8:0] slot_hi;
  logic [6:0] rack_hi;
  logic [9:0] shelf_hit;
  genvar i;
  generate
    for (i = 0; i < 10; i++) begin : g_thr
      if (i < 9) begin : g_p10
        assign unit_hi[i] = unit_level_mv >= POS10_THR[i];
        assign slot_hi[i] = slot_level_mv >= POS10_THR[i];
      end
      if (i < 7) begin : g_rack
        assign rack_hi[i] = rack_level_mv >= RACK_THR[i];
      end
      assign shelf_hit[i] = shelf_level_mv >= SHELF_MIN[i] && shelf_level_mv <= SHELF_MAX[i];
    end
  endgenerate

  // thresholds are monotonic, so a population count gives the position
  wire [3:0] unit_cnt = 4'($countones(unit_hi));
  wire [3:0] slot_cnt = 4'($countones(slot_hi));
  wire [3:0] rack_cnt = 4'($countones(rack_hi));
  wire unit_bad = unit_level_mv >= `POS10_INVALID_MV;
  wire slot_bad = slot_level_mv >= `POS10_INVALID_MV;

  assign unit_position_code = unit_bad ? `POS_NONE : 4'(4'd10 - unit_cnt);
  assign slot_position = slot_bad ? `POS_NONE : 4'(4'd10 - slot_cnt);
  assign rack_position_code = 4'(4'd8 - rack_cnt);

  always_comb begin
    shelf_position = `POS_NONE;
    for (int k = 0; k < 10; k++) begin
      if (shelf_hit[k]) begin
        shelf_position = 4'(k + 1);
      end
    end
  end
endmodule

// *** logic/address_mapper.sv ***
// maps unit and rack positions onto the four decoded address bits
// assumes positions are 1-based, 0 meaning no position
`timescale 1ns/1ps
`include "rectifier_defines.svh"
module address_mapper import rectifier_pkg::*; (
  input wire pos_t unit_position_code,
  input wire pos_t rack_position_code,
  output logic [3:0] decoded_address_bits,
  output logic address_valid
);
  wire [7:0] u = {4'h0, unit_position_code};
  wire [7:0] r = {4'h0, rack_position_code};
  wire u_1_4 = u >= 8'd1 && u <= 8'd4;
  wire u_1_5 = u >= 8'd1 && u <= 8'd5;
  wire u_6_7 = u == 8'd6 || u == 8'd7;
  wire u_8_10 = u >= 8'd8 && u <= 8'd10;
  wire r_1_4 = r >= 8'd1 && r <= 8'd4;
  wire r_6_8 = r >= 8'd6 && r <= 8'd8;
  wire r_1_8 = r >= 8'd1 && r <= 8'd8;
  wire r_4_8 = r >= 8'd4 && r <= 8'd8;

  // ==========================================================
  // four tiling regions of the unit by rack plane
  wire [7:0] code_a = 8'((r - 8'd1) * 8'd4 + (u - 8'd1));
  wire [7:0] code_b = 8'((r - 8'd6) * 8'd5 + (u - 8'd1));
  wire [7:0] code_c = 8'((r - 8'd1) * 8'd2 + (u - 8'd6));
  wire [7:0] code_d = 8'((r - 8'd4) * 8'd3 + (u - 8'd8));
  wire hit_a = u_1_4 && r_1_4;
  wire hit_b = u_1_5 && r_6_8;
  wire hit_c = u_6_7 && r_1_8;
  wire hit_d = u_8_10 && r_4_8;
  wire [7:0] code_sel = hit_a ? code_a : hit_b ? code_b : hit_c ? code_c : code_d;

  assign address_valid = hit_a | hit_b | hit_c | hit_d;
  assign decoded_address_bits = address_valid ? code_sel[3:0] : 4'h0;
endmodule

// *** logic/rectifier_id_control_status.sv ***
// identity decode, setpoint arbitration, output gating and status pins
// assumes digitised pin levels and decoded bus commands arrive synchronous
// to ref_clk; reset_n is the controller bias power-on reset
`timescale 1ns/1ps
`include "rectifier_defines.svh"

module rectifier_id_control_status import rectifier_pkg::*; #(
  parameter int PG_PULSE_CYCLES = `CLK_HZ / 1000000 * `PG_PULSE_TIME_US,
  parameter int OTW_LEAD_CYCLES = `CLK_HZ * `OTW_LEAD_TIME_S
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire mv_t unit_level_mv,
  input wire mv_t rack_level_mv,
  input wire mv_t slot_level_mv,
  input wire mv_t shelf_level_mv,
  input wire mv_t hw_voltage_setpoint_pin,
  input wire logic protocol_resistor_present,
  input wire logic on_off_n,
  input wire logic interlock_mated,
  input wire logic cmd_valid,
  input wire logic cmd_read,
  input wire logic cmd_broadcast,
  input wire logic cmd_set_vout,
  input wire mv_t cmd_vout_mv,
  input wire logic clear_faults,
  input wire logic fan_fail,
  input wire logic overtemp_detect,
  input wire logic overvoltage_shutdown,
  input wire logic internal_fault,
  input wire logic overload,
  input wire logic regulation_ok,
  output logic rs485_mode,
  output logic [7:0] bus_address_byte,
  output logic bus_address_valid,
  output pos_t bay_identity,
  output pos_t slot_identity,
  output pos_t shelf_identity,
  output logic sw_control_latched,
  output logic sw_control_indicated,
  output mv_t vout_setpoint_mv,
  output logic ramp_busy,
  output logic main_output_on,
  output logic invalid_command,
  output logic power_good_warning_n,
  output logic replace_fault_n,
  output logic overtemp_warning_n
);
  // one millivolt per tick keeps a 10 V step inside its time budget
  localparam int RAMP_TICK_CYCLES = `CLK_HZ / 1000 * `RAMP_TIME_MS / `RAMP_SPAN_MV;

  // ==========================================================
  // position decode
  pos_t unit_position_code;
  pos_t rack_position_code;
  pos_t slot_position;
  pos_t shelf_position;
  logic [3:0] decoded_address_bits;
  logic map_valid;

  position_quantiser u_quant (
    .unit_level_mv(unit_level_mv),
    .rack_level_mv(rack_level_mv),
    .slot_level_mv(slot_level_mv),
    .shelf_level_mv(shelf_level_mv),
    .unit_position_code(unit_position_code),
    .rack_position_code(rack_position_code),
    .slot_position(slot_position),
    .shelf_position(shelf_position)
  );

  address_mapper u_map (
    .unit_position_code(unit_position_code),
    .rack_position_code(rack_position_code),
    .decoded_address_bits(decoded_address_bits),
    .address_valid(map_valid)
  );

  wire [7:0] addr_byte_next = {`ADDR_BASE_BITS, decoded_address_bits, 1'b0};
  wire mode_next = protocol_resistor_present;

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      rs485_mode <= 1'b0;
    end else if (clk_en) begin
      rs485_mode <= mode_next;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      bus_address_byte <= 8'h00;
      bus_address_valid <= 1'b0;
    end else if (clk_en) begin
      bus_address_byte <= addr_byte_next;
      bus_address_valid <= map_valid && !mode_next;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      bay_identity <= `POS_NONE;
      slot_identity <= `POS_NONE;
      shelf_identity <= `POS_NONE;
    end else if (clk_en) begin
      bay_identity <= mode_next ? unit_position_code : `POS_NONE;
      slot_identity <= mode_next ? slot_position : `POS_NONE;
      shelf_identity <= mode_next ? shelf_position : `POS_NONE;
    end
  end

  // ==========================================================
  // broadcast command check
  wire bad_broadcast = cmd_valid && cmd_broadcast && cmd_read;
  logic invalid_next;
  // a new violation in the clearing cycle survives the clear
  assign invalid_next = bad_broadcast | (invalid_command & ~clear_faults);

  // ==========================================================
  // setpoint arbitration
  wire sw_write = cmd_valid && !cmd_read && cmd_set_vout;
  wire pin_default = hw_voltage_setpoint_pin > `HW_VOLTAGE_SETPOINT_PIN_DEFAULT_ABOVE_MV;
  wire [31:0] pin_scaled = 32'(hw_voltage_setpoint_pin) * 32'(`VOUT_SPAN_MV) / 32'd3000;
  wire mv_t pin_target = pin_default ? `VOUT_DEFAULT_MV
                                     : 16'(`VOUT_MIN_MV + pin_scaled[15:0]);
  mv_t sw_target_reg;
  mv_t sw_target_next;
  logic sw_latch_next;
  assign sw_latch_next = sw_control_latched | sw_write;
  assign sw_target_next = sw_write ? cmd_vout_mv : sw_target_reg;
  // pin keeps steering until a command lands, which holds a hot-plug safe level
  wire mv_t target_mv = sw_control_latched ? sw_target_reg : pin_target;

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      sw_control_latched <= 1'b0;
      sw_target_reg <= `VOUT_DEFAULT_MV;
    end else if (clk_en) begin
      sw_control_latched <= sw_latch_next;
      sw_target_reg <= sw_target_next;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      sw_control_indicated <= 1'b0;
    end else if (clk_en) begin
      sw_control_indicated <= hw_voltage_setpoint_pin < `HW_VOLTAGE_SETPOINT_PIN_GROUND_BELOW_MV;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      invalid_command <= 1'b0;
    end else if (clk_en) begin
      invalid_command <= invalid_next;
    end
  end

  // ==========================================================
  // setpoint ramp
  logic [15:0] ramp_cnt_reg;
  wire ramp_tick = ramp_cnt_reg == 16'(RAMP_TICK_CYCLES - 1);
  wire [15:0] ramp_cnt_next = ramp_tick ? 16'h0000 : 16'(ramp_cnt_reg + 16'h0001);
  wire below = vout_setpoint_mv < target_mv;
  wire above = vout_setpoint_mv > target_mv;
  assign ramp_busy = below | above;
  wire mv_t setpoint_next = !ramp_tick ? vout_setpoint_mv :
                            below ? 16'(vout_setpoint_mv + 16'h0001) :
                            above ? 16'(vout_setpoint_mv - 16'h0001) : vout_setpoint_mv;

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      ramp_cnt_reg <= 16'h0000;
      vout_setpoint_mv <= `VOUT_MIN_MV;
    end else if (clk_en) begin
      ramp_cnt_reg <= ramp_cnt_next;
      vout_setpoint_mv <= setpoint_next;
    end
  end

  // ==========================================================
  // over-temperature sequence
  ot_state_e ot_state_reg;
  ot_state_e ot_state_next;
  logic [31:0] ot_cnt_reg;
  wire ot_expired = ot_cnt_reg == 32'(OTW_LEAD_CYCLES - 1);

  always_comb begin
    case (ot_state_reg)
      OT_NORMAL: begin
        if (overtemp_detect) begin
          ot_state_next = OT_WARNING;
        end else begin
          ot_state_next = OT_NORMAL;
        end
      end
      OT_WARNING: begin
        if (!overtemp_detect) begin
          ot_state_next = OT_NORMAL;
        end else if (ot_expired) begin
          ot_state_next = OT_SHUTDOWN;
        end else begin
          ot_state_next = OT_WARNING;
        end
      end
      // auto restart once the temperature recovers
      OT_SHUTDOWN: begin
        if (overtemp_detect) begin
          ot_state_next = OT_SHUTDOWN;
        end else begin
          ot_state_next = OT_NORMAL;
        end
      end
      default: ot_state_next = OT_NORMAL;
    endcase
  end

  wire [31:0] ot_cnt_next = (ot_state_reg == OT_WARNING) ? 32'(ot_cnt_reg + 32'd1) : 32'd0;
  wire ot_shutdown = ot_state_reg == OT_SHUTDOWN;

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      ot_state_reg <= OT_NORMAL;
      ot_cnt_reg <= 32'd0;
    end else if (clk_en) begin
      ot_state_reg <= ot_state_next;
      ot_cnt_reg <= ot_cnt_next;
    end
  end

  // ==========================================================
  // output gating
  // shorted slot reads as the last slot; rs485 needs only a valid slot resistor
  wire slot_ok = rs485_mode ? (slot_position != `POS_NONE)
                            : (slot_position == `SLOT_SHORTED);
  wire enable_ok = rs485_mode | ~on_off_n;
  wire replace_fault = fan_fail | ot_shutdown | overvoltage_shutdown | internal_fault;
  // interlock is the short pin, so dropping it alone kills the output first
  wire output_on_next = enable_ok && interlock_mated && slot_ok && !replace_fault;

  // ==========================================================
  // power-good pulse in overload
  logic [15:0] pg_cnt_reg;
  logic pg_phase_reg;
  wire pg_wrap = pg_cnt_reg == 16'(PG_PULSE_CYCLES - 1);
  wire [15:0] pg_cnt_next = (!overload || pg_wrap) ? 16'h0000 : 16'(pg_cnt_reg + 16'h0001);
  wire pg_phase_next = !overload ? 1'b1 : (pg_wrap ? ~pg_phase_reg : pg_phase_reg);
  wire pg_next = main_output_on && regulation_ok && (!overload || pg_phase_reg);

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      main_output_on <= 1'b0;
    end else if (clk_en) begin
      main_output_on <= output_on_next;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      pg_cnt_reg <= 16'h0000;
      pg_phase_reg <= 1'b1;
      power_good_warning_n <= 1'b0;
    end else if (clk_en) begin
      pg_cnt_reg <= pg_cnt_next;
      pg_phase_reg <= pg_phase_next;
      power_good_warning_n <= pg_next;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      replace_fault_n <= 1'b1;
      overtemp_warning_n <= 1'b1;
    end else if (clk_en) begin
      replace_fault_n <= ~replace_fault;
      overtemp_warning_n <= ot_state_next == OT_NORMAL;
    end
  end
endmodule

// *** verif/rectifier_checker.sv ***
// assertions on the identity, control and status pins of the top module
// assumes short counts are bound in; clk_en drops only while watched inputs rest
`timescale 1ns/1ps
module rectifier_checker import rectifier_pkg::*; #(
  parameter int PG_PULSE_CYCLES = 8,
  parameter int OTW_LEAD_CYCLES = 20
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire mv_t hw_voltage_setpoint_pin,
  input wire logic protocol_resistor_present,
  input wire logic on_off_n,
  input wire logic interlock_mated,
  input wire logic cmd_valid,
  input wire logic cmd_read,
  input wire logic cmd_broadcast,
  input wire logic cmd_set_vout,
  input wire logic fan_fail,
  input wire logic overvoltage_shutdown,
  input wire logic internal_fault,
  input wire logic overload,
  input wire logic rs485_mode,
  input wire logic [7:0] bus_address_byte,
  input wire logic bus_address_valid,
  input wire logic sw_control_latched,
  input wire logic sw_control_indicated,
  input wire logic main_output_on,
  input wire logic invalid_command,
  input wire logic regulation_ok,
  input wire logic power_good_warning_n,
  input wire logic replace_fault_n,
  input wire logic overtemp_warning_n
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  // ==========================================================
  // run-length helpers, long counts cannot be unrolled
  int pg_hold;
  int otw_run;
  logic pg_prev;
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      pg_prev <= 1'h0;
      pg_hold <= 0;
      otw_run <= 0;
    end else begin
      pg_prev <= power_good_warning_n;
      pg_hold <= (overload && regulation_ok && main_output_on &&
                  pg_prev == power_good_warning_n) ? pg_hold + 1 : 0;
      otw_run <= (!overtemp_warning_n && main_output_on) ? otw_run + 1 : 0;
    end
  end
  // ==========================================================
  // properties
  out_gate_a: assert property (main_output_on |-> $past(interlock_mated)
    && ($past(protocol_resistor_present) || !$past(on_off_n)))
    else $error("output on without enable and interlock");
  bcast_read_a: assert property (cmd_valid && cmd_read && cmd_broadcast |=> invalid_command)
    else $error("broadcast read not flagged");
  read_latch_a: assert property (cmd_valid && cmd_read && !sw_control_latched
    |=> !sw_control_latched) else $error("read took software control");
  latch_set_a: assert property (cmd_valid && cmd_set_vout && !cmd_read
    |=> sw_control_latched [*3]) else $error("setpoint command did not latch");
  fault_out_a: assert property (fan_fail || overvoltage_shutdown || internal_fault
    |=> !replace_fault_n) else $error("replace fault not shown");
  otw_lead_a: assert property (otw_run <= OTW_LEAD_CYCLES + 2)
    else $error("no shutdown after warning lead time");
  otw_hold_a: assert property ($fell(overtemp_warning_n) && main_output_on
    |=> main_output_on [*8]) else $error("shutdown without warning lead");
  pg_pulse_a: assert property (pg_hold <= 2 * PG_PULSE_CYCLES)
    else $error("power good not pulsing in overload");
  pg_drop_a: assert property (!regulation_ok |=> !power_good_warning_n)
    else $error("power good high out of regulation");
  addr_form_a: assert property (bus_address_valid |-> bus_address_byte[7:5] == 3'h4
    && !bus_address_byte[0] && !rs485_mode) else $error("bad bus address byte");
  sw_ind_a: assert property (hw_voltage_setpoint_pin < 16'h0064 |=> sw_control_indicated)
    else $error("grounded setpoint pin not seen");
  cover property (cmd_valid && cmd_read && cmd_broadcast);
  cover property ($fell(main_output_on) && !overtemp_warning_n);
  cover property (overload && main_output_on && !power_good_warning_n);
endmodule

bind rectifier_id_control_status rectifier_checker #(.PG_PULSE_CYCLES(PG_PULSE_CYCLES),
  .OTW_LEAD_CYCLES(OTW_LEAD_CYCLES)) checker_i (.ref_clk, .reset_n, .hw_voltage_setpoint_pin,
  .protocol_resistor_present, .on_off_n, .interlock_mated, .cmd_valid, .cmd_read,
  .cmd_broadcast, .cmd_set_vout, .fan_fail, .overvoltage_shutdown, .internal_fault, .overload,
  .rs485_mode, .bus_address_byte, .bus_address_valid, .sw_control_latched,
  .sw_control_indicated, .main_output_on, .invalid_command, .regulation_ok,
  .power_good_warning_n, .replace_fault_n, .overtemp_warning_n);

// *** verif/shelf_wiring.sv ***
// shelf and backplane wiring: turns position numbers into pin levels in mV
// assumes positions 1..10 (rack 1..8), 0 meaning an open pin; jitter stays within +-99 mV
`timescale 1ns/1ps
module shelf_wiring import rectifier_pkg::*; (
  input wire pos_t unit_pos,
  input wire pos_t rack_pos,
  input wire pos_t slot_pos,
  input wire pos_t shelf_pos,
  input wire logic signed [7:0] jitter,
  output mv_t unit_level_mv,
  output mv_t rack_level_mv,
  output mv_t slot_level_mv,
  output mv_t shelf_level_mv
);
  // ==========================================================
  // nominal divider levels, index 0 is the open pin pulled up
  localparam int TEN_MV [0:10] = '{3300, 3000, 2670, 2340, 2010, 1680, 1350, 1020, 690, 360, 0};
  localparam int RACK_MV [0:8] = '{3300, 3300, 2800, 2300, 1800, 1400, 1000, 500, 0};
  // a divider cannot go below ground, so jitter clamps at zero
  function automatic mv_t lv(int nom, logic signed [7:0] j);
    return (nom + j < 0) ? 16'h0000 : 16'(nom + j);
  endfunction
  assign unit_level_mv = lv(TEN_MV[unit_pos], jitter);
  assign rack_level_mv = lv(RACK_MV[rack_pos], jitter);
  assign slot_level_mv = lv(TEN_MV[slot_pos], jitter);
  assign shelf_level_mv = lv(2500 * shelf_pos, jitter);
endmodule

// *** verif/testbench.sv ***
// self-checking bench for the identity, control and status block
// assumes short pulse and lead counts; the wiring model makes the pin levels
`timescale 1ns/1ps
module testbench import rectifier_pkg::*;;
  typedef struct {string n; logic [15:0] v;} note_s;
  note_s notes[$];
  event chk;
  int fails = 0;
  int checked = 0;
  logic ref_clk, reset_n, protocol_resistor_present, on_off_n, interlock_mated;
  logic clear_faults, regulation_ok, clk_en;
  logic [3:0] cmd;
  logic [4:0] flt;
  logic signed [7:0] jit;
  pos_t u, r, s, sh, bay_identity, slot_identity, shelf_identity;
  mv_t hw_voltage_setpoint_pin, cmd_vout_mv, vout_setpoint_mv;
  mv_t unit_level_mv, rack_level_mv, slot_level_mv, shelf_level_mv;
  logic rs485_mode, bus_address_valid, sw_control_latched, sw_control_indicated, ramp_busy;
  logic main_output_on, invalid_command, power_good_warning_n, replace_fault_n;
  logic overtemp_warning_n;
  logic [7:0] bus_address_byte;
  logic [4:0] e;
  int step;
  shelf_wiring wiring (.unit_pos(u), .rack_pos(r), .slot_pos(s), .shelf_pos(sh), .jitter(jit),
    .unit_level_mv, .rack_level_mv, .slot_level_mv, .shelf_level_mv);
  rectifier_id_control_status #(.PG_PULSE_CYCLES(8), .OTW_LEAD_CYCLES(20)) DUT (
    .ref_clk, .reset_n, .clk_en, .unit_level_mv, .rack_level_mv, .slot_level_mv,
    .shelf_level_mv, .hw_voltage_setpoint_pin, .protocol_resistor_present, .on_off_n,
    .interlock_mated, .cmd_valid(cmd[3]), .cmd_read(cmd[2]), .cmd_broadcast(cmd[1]),
    .cmd_set_vout(cmd[0]), .cmd_vout_mv, .clear_faults, .fan_fail(flt[0]),
    .overtemp_detect(flt[1]), .overvoltage_shutdown(flt[2]), .internal_fault(flt[3]),
    .overload(flt[4]), .regulation_ok, .rs485_mode, .bus_address_byte, .bus_address_valid,
    .bay_identity, .slot_identity, .shelf_identity, .sw_control_latched,
    .sw_control_indicated, .vout_setpoint_mv, .ramp_busy, .main_output_on, .invalid_command,
    .power_good_warning_n, .replace_fault_n, .overtemp_warning_n);
  // ==========================================================
  // shared tasks
  function automatic logic [15:0] seen(string n);
    case (n)
      "valid": return 16'(bus_address_valid);
      "byte": return 16'(bus_address_byte);
      "bay": return 16'(bay_identity);
      "slot": return 16'(slot_identity);
      "shelf": return 16'(shelf_identity);
      "main": return 16'(main_output_on);
      "pg": return 16'(power_good_warning_n);
      "warn": return 16'(overtemp_warning_n);
      "repl": return 16'(replace_fault_n);
      "inval": return 16'(invalid_command);
      "latch": return 16'(sw_control_latched);
      "ind": return 16'(sw_control_indicated);
      "ramp": return 16'(ramp_busy);
      default: return vout_setpoint_mv;
    endcase
  endfunction
  // {valid, code}: blank cells of the position table give no address
  function automatic logic [4:0] map(int ui, int ri);
    if (ui <= 4 && ri <= 4) return {1'h1, 4'((ri - 1) * 4 + ui - 1)};
    if (ui <= 5 && ri >= 6) return {1'h1, 4'((ri - 6) * 5 + ui - 1)};
    if (ui >= 6 && ui <= 7) return {1'h1, 4'((ri - 1) * 2 + ui - 6)};
    if (ui >= 8 && ri >= 4) return {1'h1, 4'((ri - 4) * 3 + ui - 8)};
    return 5'h00;
  endfunction
  task automatic tick(int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task automatic note(string n, logic [15:0] v);
    notes.push_back('{n, v});
  endtask
  task automatic observe();
    tick(2);
    -> chk;
    tick(1);
  endtask
  task automatic send(logic [3:0] c, mv_t v);
    cmd <= c;
    cmd_vout_mv <= v;
    tick(1);
    cmd <= 4'h0;
  endtask
  task automatic check(string n, logic [15:0] sv, logic [15:0] ev);
    checked++;
    if (sv !== ev) begin
      fails++;
      $display("BAD %s expected %h seen %h", n, ev, sv);
    end
  endtask
  task automatic wait_for(string n, logic [15:0] v, int lim);
    int i;
    for (i = 0; i < lim && seen(n) !== v; i++) tick(1);
    if (i == lim) begin
      check(n, seen(n), v);
      results();
    end
  endtask
  task automatic results();
    if (fails == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    ref_clk = 1'h0;
    forever #10 ref_clk = ~ref_clk;
  end
  initial begin
    forever begin
      @(chk);
      #1;
      while (notes.size() > 0) begin
        check(notes[0].n, seen(notes[0].n), notes[0].v);
        void'(notes.pop_front());
      end
    end
  end
  // ==========================================================
  // main sequence
  initial begin
    reset_n = 1'h0;
    protocol_resistor_present = 1'h0;
    on_off_n = 1'h1;
    interlock_mated = 1'h0;
    clear_faults = 1'h0;
    clk_en = 1'h1;
    regulation_ok = 1'h1;
    cmd = 4'h0;
    flt = 5'h00;
    jit = 8'sh00;
    u = 4'h1;
    r = 4'h1;
    s = 4'ha;
    sh = 4'h0;
    hw_voltage_setpoint_pin = 16'h0000;
    cmd_vout_mv = 16'h0000;
    void'($urandom(25688));
    tick(4);
    reset_n <= 1'h1;
    note("ind", 1);
    note("latch", 0);
    note("ramp", 0);
    note("vout", 16'd18000);
    observe();
    for (int ui = 1; ui <= 10; ui++) begin
      for (int ri = 1; ri <= 8; ri++) begin
        e = map(ui, ri);
        u <= 4'(ui);
        r <= 4'(ri);
        jit <= 8'($urandom_range(198) - 99);
        note("valid", 16'(e[4]));
        if (e[4]) note("byte", {8'h00, 3'h4, e[3:0], 1'h0});
        observe();
      end
    end
    protocol_resistor_present <= 1'h1;
    interlock_mated <= 1'h1;
    for (int i = 1; i <= 10; i++) begin
      u <= 4'(i);
      s <= 4'(11 - i);
      sh <= 4'(i);
      jit <= 8'($urandom_range(198) - 99);
      note("bay", 16'(i));
      note("slot", 16'(11 - i));
      note("shelf", 16'(i));
      note("valid", 0);
      note("main", 1);
      observe();
    end
    s <= 4'h0;
    note("slot", 0);
    note("main", 0);
    observe();
    protocol_resistor_present <= 1'h0;
    u <= 4'h2;
    r <= 4'h1;
    for (int k = 0; k < 8; k++) begin
      on_off_n <= k[0];
      interlock_mated <= k[1];
      s <= k[2] ? 4'ha : 4'h1;
      note("main", 16'(!k[0] && k[1] && k[2]));
      observe();
    end
    on_off_n <= 1'h0;
    s <= 4'ha;
    regulation_ok <= 1'h0;
    note("pg", 0);
    observe();
    regulation_ok <= 1'h1;
    note("pg", 1);
    observe();
    flt <= 5'h10;
    tick(40);
    flt <= 5'h02;
    note("warn", 0);
    note("main", 1);
    observe();
    wait_for("main", 0, 40);
    note("repl", 0);
    note("warn", 0);
    observe();
    flt <= 5'h00;
    note("warn", 1);
    note("main", 1);
    observe();
    for (int k = 0; k < 3; k++) begin
      send(k == 0 ? 4'hc : k == 1 ? 4'ha : 4'he, 16'h0000);
      note("inval", 16'(k == 2));
      note("latch", 0);
      observe();
    end
    clear_faults <= 1'h1;
    tick(1);
    clear_faults <= 1'h0;
    note("inval", 0);
    observe();
    step = $urandom_range(4) + 2;
    send(4'hb, 16'(18000 + step));
    note("latch", 1);
    observe();
    wait_for("ramp", 0, 300 * step + 600);
    send(4'hc, 16'h0000);
    note("vout", 16'(18000 + step));
    observe();
    hw_voltage_setpoint_pin <= 16'd3300;
    note("vout", 16'(18000 + step));
    note("ramp", 0);
    note("ind", 0);
    observe();
    clk_en <= 1'h0;
    u <= 4'h3;
    note("byte", 16'h0082);
    observe();
    clk_en <= 1'h1;
    note("byte", 16'h0084);
    observe();
    foreach (e[i]) begin
      if (i == 0 || i == 2 || i == 3) begin
        flt <= 5'(1 << i);
        note("repl", 0);
        observe();
        flt <= 5'h00;
        tick(1);
      end
    end
    reset_n <= 1'h0;
    tick(2);
    reset_n <= 1'h1;
    note("latch", 0);
    note("ramp", 1);
    observe();
    results();
  end
endmodule
